// ==== gtc_regs.sv ====
// timer configuration, mode and control registers with avalon-mm slave
// Function
// - config field 2:0 value 0 selects one 32-bit timer.
// - config value 1 selects one 32-bit real-time-clock counter.
// - config values 4 to 7 split into two 16-bit timers.
// - mode field decodes 1 one-shot, 2 periodic, 3 capture; 0 reserved.
// - mode bit 2 picks edge count (0) or edge time (1).
// - mode bit 3 picks capture (0) or PWM (1).
// - in 32-bit arrangement only the timer A mode register counts.
// - in 16-bit arrangement each mode register governs its own timer.
// - control bits 0 and 8 enable timer A and B.
// - control bits 1 and 9 permit stalling of timer A and B.
// - event fields 3:2 and 11:10 select rising, falling or both edges.
// - control bit 4 lets the real-time-clock counter count.
// - control bits 5 and 13 enable the trigger outputs.
// - control bits 6 and 14 invert the PWM outputs.
// - reserved bits read zero; control bits 7 and 12 read zero.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module gtc_regs (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire gtc_pkg::gtc_bus_req_t i_bus,
	output gtc_pkg::gtc_bus_rsp_t o_bus,
	output gtc_pkg::gtc_arr_t o_arrangement,
	output gtc_pkg::gtc_timer_t o_timer_a,
	output gtc_pkg::gtc_timer_t o_timer_b,
	output logic o_rtc_count_en
);
	import gtc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [GTC_CFG_W-1:0] cfg;
		logic [GTC_MODE_W-1:0] amode;
		logic [GTC_MODE_W-1:0] bmode;
		logic [GTC_CTL_W-1:0] ctl;
		logic ack;
		logic [31:0] rdata;
		gtc_arr_t arr;
		gtc_timer_t ta;
		gtc_timer_t tb;
		logic rtc_en;
	} gtc_state_t;

	gtc_state_t state_q;
	gtc_state_t state_d;
	gtc_timer_t dec_a;
	gtc_timer_t dec_b;
	gtc_arr_t arr_next;
	logic [GTC_MODE_W-1:0] b_src;
	logic split;

	function automatic gtc_arr_t arr_of(input logic [GTC_CFG_W-1:0] cfg);
		if (cfg[GTC_CFG_SPLIT_BIT]) begin
			arr_of = GTC_ARR_SPLIT;
		end else if (cfg == GTC_CFG_SINGLE) begin
			arr_of = GTC_ARR_SINGLE;
		end else if (cfg == GTC_CFG_RTC) begin
			arr_of = GTC_ARR_RTC;
		end else begin
			arr_of = GTC_ARR_RSVD;
		end
	endfunction

	// ----------------------------------------------------------------
	// decode of the register contents
	// ----------------------------------------------------------------
	assign arr_next = arr_of(state_d.cfg);
	assign split = (arr_next == GTC_ARR_SPLIT);
	// timer B mode only matters when split
	assign b_src = split ? state_d.bmode : state_d.amode;

	gtc_mode_decode u_dec_a (
		.i_mode(state_d.amode),
		.i_ctl(state_d.ctl[6:0]),
		.i_active(1'b1),
		.o_timer(dec_a)
	);

	gtc_mode_decode u_dec_b (
		.i_mode(b_src),
		.i_ctl(state_d.ctl[GTC_B_SHIFT+:7]),
		.i_active(split),
		.o_timer(dec_b)
	);

	// ----------------------------------------------------------------
	// bus slave and next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.ack = 1'b0;
		if ((i_bus.read || i_bus.write) && !state_q.ack) begin
			state_d.ack = 1'b1;
			if (i_bus.read) begin
				unique case (i_bus.address)
					GTC_OFS_CFG: state_d.rdata = {29'h0, state_q.cfg};
					GTC_OFS_AMODE: state_d.rdata = {28'h0, state_q.amode};
					GTC_OFS_BMODE: state_d.rdata = {28'h0, state_q.bmode};
					GTC_OFS_CTL: state_d.rdata = {17'h0, state_q.ctl};
					default: state_d.rdata = GTC_UNMAPPED_RD;
				endcase
			end
		end
		// write lands only at the edge that sees waitrequest low
		if (i_bus.write && state_q.ack) begin
			unique case (i_bus.address)
				GTC_OFS_CFG: state_d.cfg = i_bus.writedata[GTC_CFG_W-1:0];
				GTC_OFS_AMODE: state_d.amode = i_bus.writedata[GTC_MODE_W-1:0];
				GTC_OFS_BMODE: state_d.bmode = i_bus.writedata[GTC_MODE_W-1:0];
				GTC_OFS_CTL: state_d.ctl =
					i_bus.writedata[GTC_CTL_W-1:0] & GTC_CTL_WMASK;
				default: state_d.cfg = state_q.cfg;
			endcase
		end
		state_d.arr = arr_next;
		state_d.ta = dec_a;
		state_d.tb = dec_b;
		state_d.rtc_en = state_d.ctl[GTC_CTL_RTC];
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_bus.waitrequest = !state_q.ack;
	assign o_bus.readdata = state_q.rdata;
	assign o_arrangement = state_q.arr;
	assign o_timer_a = state_q.ta;
	assign o_timer_b = state_q.tb;
	assign o_rtc_count_en = state_q.rtc_en;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	cfg_single_a: assert property (state_q.cfg == GTC_CFG_SINGLE
		|-> o_arrangement == GTC_ARR_SINGLE) else $error("cfg 0 not single");
	cfg_rtc_a: assert property (state_q.cfg == GTC_CFG_RTC
		|-> o_arrangement == GTC_ARR_RTC) else $error("cfg 1 not rtc");
	cfg_split_a: assert property (state_q.cfg[GTC_CFG_SPLIT_BIT]
		|-> o_arrangement == GTC_ARR_SPLIT) else $error("cfg 4-7 not split");
	mode_oneshot_a: assert property (state_q.amode[1:0] == GTC_MODE_ONESHOT
		|-> o_timer_a.op == GTC_OP_ONESHOT) else $error("one-shot decode");
	capt_type_a: assert property (state_q.amode == 4'h7
		|-> o_timer_a.op == GTC_OP_EDGE_TIME) else $error("edge time decode");
	alt_pwm_a: assert property (state_q.amode[3] && state_q.amode[1:0] == GTC_MODE_CAPTURE
		|-> o_timer_a.op == GTC_OP_PWM) else $error("pwm decode");
	b_ignored_a: assert property (!state_q.cfg[GTC_CFG_SPLIT_BIT]
		|-> o_timer_b == '0) else $error("timer b active in 32-bit");
	b_own_a: assert property (state_q.cfg[GTC_CFG_SPLIT_BIT] && state_q.bmode[1:0] == 2'h2
		|-> o_timer_b.op == GTC_OP_PERIODIC) else $error("timer b mode");
	en_bits_a: assert property (o_timer_a.enable == state_q.ctl[0]
		&& o_timer_a.stall_en == state_q.ctl[1]) else $error("a enable");
	edge_sel_a: assert property (state_q.ctl[3:2] == GTC_EVT_BOTH
		|-> o_timer_a.rise_en && o_timer_a.fall_en) else $error("edge select");
	rtc_en_a: assert property (o_rtc_count_en == state_q.ctl[4]) else $error("rtc en");
	trig_inv_a: assert property (o_timer_a.trig_en == state_q.ctl[5]
		&& o_timer_a.pwm_inv == state_q.ctl[6]) else $error("trig inv");
	rsvd_zero_a: assert property (state_q.ctl[7] == 1'b0 && state_q.ctl[12] == 1'b0)
		else $error("reserved ctl bit set");
	ack_one_a: assert property (!o_bus.waitrequest |=> o_bus.waitrequest)
		else $error("ack longer than one cycle");

	cov_split_c: cover property (o_arrangement == GTC_ARR_SPLIT && o_timer_b.enable);
	cov_pwm_c: cover property (o_timer_a.op == GTC_OP_PWM && o_timer_a.pwm_inv);
	cov_rtc_c: cover property (o_arrangement == GTC_ARR_RTC && o_rtc_count_en);

endmodule

// ==== gtc_pkg.sv ====
// package for the timer configuration, mode and control register block
package gtc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] GTC_OFS_CFG = 12'h000;
	localparam logic [11:0] GTC_OFS_AMODE = 12'h004;
	localparam logic [11:0] GTC_OFS_BMODE = 12'h008;
	localparam logic [11:0] GTC_OFS_CTL = 12'h00C;
	localparam logic [31:0] GTC_RESET_VAL = 32'h00000000;
	localparam logic [31:0] GTC_UNMAPPED_RD = 32'h00000000;

	// field layout
	localparam int GTC_CFG_W = 3;
	localparam int GTC_MODE_W = 4;
	localparam int GTC_CTL_W = 15;
	localparam logic [2:0] GTC_CFG_SINGLE = 3'h0;
	localparam logic [2:0] GTC_CFG_RTC = 3'h1;
	localparam int GTC_CFG_SPLIT_BIT = 2;
	localparam logic [1:0] GTC_MODE_ONESHOT = 2'h1;
	localparam logic [1:0] GTC_MODE_PERIODIC = 2'h2;
	localparam logic [1:0] GTC_MODE_CAPTURE = 2'h3;
	localparam int GTC_MODE_CAPT_BIT = 2;
	localparam int GTC_MODE_ALT_BIT = 3;
	localparam int GTC_B_SHIFT = 8;
	localparam int GTC_CTL_EN = 0;
	localparam int GTC_CTL_STALL = 1;
	localparam int GTC_CTL_EVT = 2;
	localparam int GTC_CTL_RTC = 4;
	localparam int GTC_CTL_OTE = 5;
	localparam int GTC_CTL_PWMI = 6;
	// writable control bits; 7 and 12 stay zero
	localparam logic [14:0] GTC_CTL_WMASK = 15'h6F7F;
	localparam logic [1:0] GTC_EVT_RISE = 2'h0;
	localparam logic [1:0] GTC_EVT_FALL = 2'h1;
	localparam logic [1:0] GTC_EVT_BOTH = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GTC_ARR_SINGLE = 2'h0,
		GTC_ARR_RTC = 2'h1,
		GTC_ARR_SPLIT = 2'h3,
		GTC_ARR_RSVD = 2'h2
	} gtc_arr_t;

	typedef enum logic [2:0] {
		GTC_OP_OFF = 3'h0,
		GTC_OP_ONESHOT = 3'h1,
		GTC_OP_PERIODIC = 3'h3,
		GTC_OP_EDGE_CNT = 3'h2,
		GTC_OP_EDGE_TIME = 3'h6,
		GTC_OP_PWM = 3'h7,
		GTC_OP_RSVD = 3'h5
	} gtc_op_t;

	// decoded controls of one timer half
	typedef struct packed {
		gtc_op_t op;
		logic enable;
		logic stall_en;
		logic rise_en;
		logic fall_en;
		logic trig_en;
		logic pwm_inv;
	} gtc_timer_t;

	// avalon-mm slave side
	typedef struct packed {
		logic read;
		logic write;
		logic [11:0] address;
		logic [31:0] writedata;
	} gtc_bus_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} gtc_bus_rsp_t;

endpackage

// ==== gtc_mode_decode.sv ====
// decode of one timer half from mode and control fields
`timescale 1ns/1ps
module gtc_mode_decode (
	input wire logic [gtc_pkg::GTC_MODE_W-1:0] i_mode,
	input wire logic [6:0] i_ctl,
	input wire logic i_active,
	output gtc_pkg::gtc_timer_t o_timer
);
	import gtc_pkg::*;

	always_comb begin
		o_timer = '0;
		if (i_active) begin
			unique case (i_mode[1:0])
				GTC_MODE_ONESHOT: o_timer.op = GTC_OP_ONESHOT;
				GTC_MODE_PERIODIC: o_timer.op = GTC_OP_PERIODIC;
				GTC_MODE_CAPTURE: begin
					if (i_mode[GTC_MODE_ALT_BIT]) begin
						o_timer.op = GTC_OP_PWM;
					end else if (i_mode[GTC_MODE_CAPT_BIT]) begin
						o_timer.op = GTC_OP_EDGE_TIME;
					end else begin
						o_timer.op = GTC_OP_EDGE_CNT;
					end
				end
				default: o_timer.op = GTC_OP_RSVD;
			endcase
			o_timer.enable = i_ctl[GTC_CTL_EN];
			o_timer.stall_en = i_ctl[GTC_CTL_STALL];
			// code 10 left undefined: neither edge armed
			o_timer.rise_en = (i_ctl[GTC_CTL_EVT+:2] == GTC_EVT_RISE) ||
				(i_ctl[GTC_CTL_EVT+:2] == GTC_EVT_BOTH);
			o_timer.fall_en = (i_ctl[GTC_CTL_EVT+:2] == GTC_EVT_FALL) ||
				(i_ctl[GTC_CTL_EVT+:2] == GTC_EVT_BOTH);
			o_timer.trig_en = i_ctl[GTC_CTL_OTE];
			o_timer.pwm_inv = i_ctl[GTC_CTL_PWMI];
		end
	end

endmodule

// ==== gtc_regs_tb.sv ====
// self-checking testbench for the timer configuration register block
`timescale 1ns/1ps
module gtc_regs_tb;
	import gtc_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	gtc_bus_req_t i_bus = '0;
	gtc_bus_rsp_t o_bus;
	gtc_arr_t o_arrangement;
	gtc_timer_t o_timer_a;
	gtc_timer_t o_timer_b;
	logic o_rtc_count_en;
	int failures = 0;
	int cmp_count = 0;
	logic [31:0] rd_q;
	logic [3:0] modes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'hB};
	gtc_op_t ops [6] = '{GTC_OP_RSVD, GTC_OP_ONESHOT, GTC_OP_PERIODIC, GTC_OP_EDGE_CNT,
		GTC_OP_EDGE_TIME, GTC_OP_PWM};
	logic [31:0] ctls [4] = '{32'h00007FFF, 32'h00002565, 32'h00004213, 32'h00000000};

	gtc_regs gtc_regs_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_bus(o_bus),
		.o_arrangement(o_arrangement), .o_timer_a(o_timer_a), .o_timer_b(o_timer_b),
		.o_rtc_count_en(o_rtc_count_en));

	always #5 i_clock = ~i_clock;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		@(posedge i_clock);
		i_bus <= '{read: !wr, write: wr, address: addr, writedata: data};
		do begin
			@(posedge i_clock);
		end while (o_bus.waitrequest !== 1'b0);
		rd_q = o_bus.readdata;
		i_bus <= '0;
		#1;
	endtask

	task automatic wr(input logic [11:0] addr, input logic [31:0] data);
		bus(1'b1, addr, data);
	endtask

	task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
		bus(1'b0, addr, 32'h00000000);
		chk(rd_q, exp, "readback");
	endtask

	function automatic gtc_timer_t exp_t(input gtc_op_t op, input logic [6:0] c);
		exp_t = '{op: op, enable: c[0], stall_en: c[1],
			rise_en: (c[3:2] == 2'h0 || c[3:2] == 2'h3),
			fall_en: (c[3:2] == 2'h1 || c[3:2] == 2'h3), trig_en: c[5], pwm_inv: c[6]};
	endfunction

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_clock);
		i_rst_n <= 1'b1;
		for (int a = 0; a < 4; a++) begin
			rd_chk(12'(a * 4), GTC_RESET_VAL);
		end
		chk(32'(o_arrangement), 32'(GTC_ARR_SINGLE), "reset arrangement");
		$display("test reset values done");
		for (int v = 0; v < 8; v++) begin
			if (v != 2 && v != 3) begin
				wr(GTC_OFS_CFG, 32'(v));
				rd_chk(GTC_OFS_CFG, 32'(v));
				chk(32'(o_arrangement), (v == 0) ? 32'(GTC_ARR_SINGLE) : (v == 1) ?
					32'(GTC_ARR_RTC) : 32'(GTC_ARR_SPLIT), "arrangement");
			end
		end
		$display("test configuration done");
		for (int i = 0; i < 6; i++) begin
			wr(GTC_OFS_AMODE, 32'(modes[i]));
			wr(GTC_OFS_BMODE, 32'(modes[5 - i]));
			rd_chk(GTC_OFS_AMODE, 32'(modes[i]));
			chk(32'(o_timer_a), 32'(exp_t(ops[i], 7'h00)), "timer a mode");
			chk(32'(o_timer_b), 32'(exp_t(ops[5 - i], 7'h00)), "timer b mode");
		end
		wr(GTC_OFS_BMODE, 32'h00000002);
		for (int v = 0; v < 2; v++) begin
			wr(GTC_OFS_CFG, 32'(v));
			chk(32'(o_timer_b), 32'h00000000, "timer b ignored");
			chk(32'(o_timer_a), 32'(exp_t(GTC_OP_PWM, 7'h00)), "timer a only");
		end
		$display("test modes done");
		wr(GTC_OFS_CFG, 32'h00000004);
		for (int i = 0; i < 4; i++) begin
			wr(GTC_OFS_CTL, 32'h00000000);
			wr(GTC_OFS_CTL, ctls[i]);
			rd_chk(GTC_OFS_CTL, ctls[i] & 32'h00006F7F);
			chk(32'(o_timer_a), 32'(exp_t(GTC_OP_PWM, ctls[i][6:0])),
				"timer a ctl");
			chk(32'(o_timer_b), 32'(exp_t(GTC_OP_PERIODIC, ctls[i][14:8])),
				"timer b ctl");
			chk(32'(o_rtc_count_en), 32'(ctls[i][4]), "rtc enable");
		end
		$display("test control done");
		wr(GTC_OFS_CTL, 32'h00000021);
		wr(12'h010, 32'hFFFFFFFF);
		rd_chk(12'h010, GTC_UNMAPPED_RD);
		rd_chk(GTC_OFS_CTL, 32'h00000021);
		$display("test unmapped done");
		complete_run();
	end

	initial begin
		#200000;
		failures++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		complete_run();
	end
endmodule
